// ---- verif/zcd_src.sv ----
// Purpose: Comparator at the far side of the detector input pin.
// Assumes: Bench sets the wanted level just after a pclk edge.
// Notes:   Output lags by a fraction of a cycle, like an async input.
`timescale 1ns/1ps
`default_nettype none
module zcd_src
(
  input  wire logic pclk,
  input  wire logic level,
  output var  logic comp_above
);
  // ---------------------------------------------------------------
  // Comparator
  // ---------------------------------------------------------------
  // Odd lag keeps the change off the sampling edge
  // Pin analog, no pull: level passes unbiased
  always @(posedge pclk)
  begin
    comp_above <= #1.7 level;
  end
endmodule
`default_nettype wire

// ---- verif/zero_cross_detect_ctrl_test.sv ----
// Purpose: Self-checking bench of the zero-cross detector control.
// Assumes: One wait state on APB; 400-cycle start-up.
// Notes:   Random levels, every edge mode with and without inversion.
`timescale 1ns/1ps
`default_nettype none
`include "zcd_defines.svh"
module zero_cross_detect_ctrl_test;
  import zcd_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, level, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, comp_above, detector_enable, pin_out;
  logic        pin_out_en_n, level_event, irq, inv, msk, o_prev, o_now, flg;
  int          num_errors, checks_done;
  zcd_edge_t   es;

  zcd_src i_zcd_src (.pclk(pclk), .level(level), .comp_above(comp_above));
  zcd_ctrl i_zcd_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comp_above(comp_above), .detector_enable(detector_enable),
    .pin_out(pin_out), .pin_out_en_n(pin_out_en_n),
    .level_event(level_event), .irq(irq));

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic test_done();
    if (num_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic cmp_pin(input logic exp, input logic got);
    cmp({31'h0, exp}, {31'h0, got});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Bounded wait: a dead slave ends the run
    if (n >= 50)
    begin
      num_errors++;
      test_done();
    end
    @(posedge pclk);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(exp, rd);
  endtask

  function automatic logic edge_hit(zcd_edge_t e, logic a, logic b);
    return (a != b) && (e == ZCD_EDGE_BOTH || (e == ZCD_EDGE_RISE && b)
                        || (e == ZCD_EDGE_FALL && !b));
  endfunction

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, level, err} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    num_errors = 0;
    checks_done = 0;
    void'($urandom(32'h7696));
    cyc(20);
    presetn <= 1'b1;
    cyc(1);
    cmp_pin(1'b1, pin_out_en_n);
    rdchk(`ZCD_OFF_CTRL, 32'h0);
    rdchk(`ZCD_OFF_EDGE, 32'h0);
    rdchk(`ZCD_OFF_IRQMASK, 32'h1);
    rdchk(12'h004, 32'h0);
    cmp_pin(1'b1, err);
    apb(1'b1, 12'h014, 32'hFFFF_FFFF);
    cmp_pin(1'b1, err);
    apb(1'b1, `ZCD_OFF_CTRL, 32'h41);
    cyc(3);
    cmp_pin(1'b1, detector_enable);
    cmp_pin(1'b0, pin_out_en_n);
    level <= 1'b1;
    cyc(20);
    cmp_pin(1'b0, pin_out);
    rdchk(`ZCD_OFF_STATUS, 32'h0);
    cyc(`ZCD_STARTUP_CYC);
    rdchk(`ZCD_OFF_STATUS, 32'h30);
    for (int k = 0; k < 16; k++)
    begin
      es = zcd_edge_t'(k[1:0]);
      inv = k[2];
      msk = k[3];
      apb(1'b1, `ZCD_OFF_EDGE, {30'h0, es});
      apb(1'b1, `ZCD_OFF_IRQMASK, {31'h0, msk});
      apb(1'b1, `ZCD_OFF_CTRL, {25'h0, 1'b1, 2'h0, inv, 3'h1});
      cyc(10);
      apb(1'b1, `ZCD_OFF_STATUS, 32'h1);
      o_prev = level ^ inv;
      repeat (4)
      begin
        level <= 1'($urandom);
        cyc(10);
        o_now = level ^ inv;
        flg = edge_hit(es, o_prev, o_now);
        rdchk(`ZCD_OFF_STATUS, {27'h1, o_now, 3'h0, flg});
        cmp_pin(flg & msk, irq);
        cmp_pin(o_now, pin_out);
        cmp_pin(o_now, level_event);
        apb(1'b1, `ZCD_OFF_STATUS, 32'h1);
        o_prev = o_now;
      end
    end
    apb(1'b1, `ZCD_OFF_CTRL, 32'h0);
    cyc(3);
    cmp_pin(1'b0, detector_enable);
    cmp_pin(1'b0, pin_out);
    test_done();
  end
endmodule
`default_nettype wire

// ---- verilog/zcd_ctrl.sv ----
// Purpose: Control and status logic of a zero-cross detector behind APB.
// Assumes: Comparator level is asynchronous; pclk 200 MHz.
// Notes:   Output pin, event and status use the synchronised level.
//
// What this block does
// - Without inversion, state reads 1 above threshold and 0 below.
// - Inversion bit set reverses the reported state polarity.
// - Edge detection for interrupts works on the inverted output too.
// - Output pin enable bit routes the detector output to its pin.
// - Enable bit switches the detector on.
// - Output ignored during start-up interval after enable.
// - Two-bit edge select picks rising, falling or both edges.
// - Configured crossing sets the sticky crossing flag.
// - Interrupt high while source enabled, edge select not off and flag set, until cleared.
// - Level event output follows the detector output level.
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "zcd_defines.svh"
module zcd_ctrl
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        comp_above,
  output var  logic        detector_enable,
  output var  logic        pin_out,
  output var  logic        pin_out_en_n,
  output var  logic        level_event,
  output var  logic        irq
);
  import zcd_pkg::*;

  localparam logic [11:0] STARTUP_CYC = 12'(`ZCD_STARTUP_CYC);

  // -------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------
  logic [7:0]  ctrl_q;
  zcd_edge_t   edge_q;
  logic        cross_q;
  logic        mask_q;
  zcd_state_t  st_q;
  logic [11:0] cnt_q;
  logic        sync_lvl;
  logic        out_q;
  logic        out_prev_q;
  logic        hit;
  logic        wr_acc;
  logic        acc;
  logic        mapped;
  logic        out_d;

  assign acc    = psel && penable && !pready;
  assign wr_acc = acc && pwrite;
  assign mapped = (paddr == `ZCD_OFF_CTRL) || (paddr == `ZCD_OFF_EDGE) ||
                  (paddr == `ZCD_OFF_STATUS) || (paddr == `ZCD_OFF_IRQMASK);

  zcd_sync u_sync
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (comp_above),
    .sync_out (sync_lvl)
  );

  // -------------------------------------------------------------------
  // Control registers
  // -------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= `ZCD_CTRL_RST;
      edge_q <= zcd_edge_t'(`ZCD_EDGE_RST);
      mask_q <= `ZCD_MASK_RST;
    end
    else if (wr_acc)
    begin
      if (paddr == `ZCD_OFF_CTRL)
      begin
        ctrl_q <= pwdata[7:0] & 8'hC9;
      end
      if (paddr == `ZCD_OFF_EDGE)
      begin
        edge_q <= zcd_edge_t'(pwdata[1:0]);
      end
      if (paddr == `ZCD_OFF_IRQMASK)
      begin
        mask_q <= pwdata[0];
      end
    end
  end

  // -------------------------------------------------------------------
  // Start-up sequencing
  // -------------------------------------------------------------------
  // Comparator output is unreliable while it settles after enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q  <= ZCD_ST_OFF;
      cnt_q <= 12'h000;
    end
    else if (!ctrl_q[`ZCD_CTRL_ENABLE])
    begin
      st_q  <= ZCD_ST_OFF;
      cnt_q <= 12'h000;
    end
    else
    begin
      unique case (st_q)
        ZCD_ST_OFF:
        begin
          st_q  <= ZCD_ST_WAIT;
          cnt_q <= 12'h000;
        end
        ZCD_ST_WAIT:
        begin
          cnt_q <= cnt_q + 12'h001;
          if (cnt_q == STARTUP_CYC - 12'h001)
          begin
            st_q <= ZCD_ST_RUN;
          end
        end
        ZCD_ST_RUN:
        begin
          cnt_q <= STARTUP_CYC + 12'h001;
        end
        default:
        begin
          st_q <= ZCD_ST_OFF;
        end
      endcase
    end
  end

  // -------------------------------------------------------------------
  // Detector output, edges and flag
  // -------------------------------------------------------------------
  assign out_d = (st_q == ZCD_ST_RUN) &&
                 (sync_lvl ^ ctrl_q[`ZCD_CTRL_INVERT]);

  always_comb
  begin
    unique case (edge_q)
      ZCD_EDGE_OFF:  hit = 1'b0;
      ZCD_EDGE_RISE: hit = out_q && !out_prev_q;
      ZCD_EDGE_FALL: hit = !out_q && out_prev_q;
      ZCD_EDGE_BOTH: hit = out_q != out_prev_q;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_q      <= 1'b0;
      out_prev_q <= 1'b0;
    end
    else
    begin
      out_q      <= out_d;
      out_prev_q <= (cnt_q > STARTUP_CYC) ? out_q : out_d;
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cross_q <= 1'b0;
    end
    else if (hit)
    begin
      cross_q <= 1'b1;
    end
    else if (wr_acc && paddr == `ZCD_OFF_STATUS && pwdata[`ZCD_ST_CROSS])
    begin
      cross_q <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      detector_enable <= 1'b0;
      pin_out         <= 1'b0;
      pin_out_en_n    <= 1'b1;
      level_event     <= 1'b0;
      irq             <= 1'b0;
    end
    else
    begin
      detector_enable <= ctrl_q[`ZCD_CTRL_ENABLE];
      pin_out         <= out_d;
      pin_out_en_n    <= !ctrl_q[`ZCD_CTRL_PIN_EN];
      level_event     <= out_d;
      irq             <= (cross_q || hit) && mask_q &&
                         (edge_q != ZCD_EDGE_OFF);
    end
  end

  // -------------------------------------------------------------------
  // APB slave: one wait state, unmapped gives pslverr
  // -------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= acc;
      pslverr <= acc && !mapped;
      prdata  <= 32'h0000_0000;
      if (acc && !pwrite)
      begin
        if (paddr == `ZCD_OFF_CTRL)
        begin
          prdata[7:0] <= ctrl_q;
        end
        if (paddr == `ZCD_OFF_EDGE)
        begin
          prdata[1:0] <= edge_q;
        end
        if (paddr == `ZCD_OFF_STATUS)
        begin
          prdata[`ZCD_ST_CROSS] <= cross_q;
          prdata[`ZCD_ST_STATE] <= out_q;
          prdata[`ZCD_ST_READY] <= (st_q == ZCD_ST_RUN);
        end
        if (paddr == `ZCD_OFF_IRQMASK)
        begin
          prdata[0] <= mask_q;
        end
      end
    end
  end

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  rise_sets_flag_a: assert property (
    (hit && edge_q == ZCD_EDGE_RISE) |=> cross_q)
    else $error("rising edge did not set flag");
  edge_needs_mode_a: assert property (
    $rose(cross_q) |-> $past(edge_q) != ZCD_EDGE_OFF)
    else $error("flag set with edges disabled");
  irq_follows_flag_a: assert property (
    (cross_q && mask_q && edge_q != ZCD_EDGE_OFF) |=> irq)
    else $error("irq missing while flag set");
  no_irq_clear_a: assert property (
    (!cross_q && !hit) |=> !irq)
    else $error("irq without flag");
  startup_quiet_a: assert property (
    (st_q != ZCD_ST_RUN) |=> !out_q)
    else $error("output before start-up end");
  invert_level_a: assert property (
    (st_q == ZCD_ST_RUN) |=>
      out_q == ($past(comp_above, 3) ^ $past(ctrl_q[`ZCD_CTRL_INVERT])))
    else $error("state polarity wrong");
  event_tracks_a: assert property (
    ##1 level_event == $past(out_d))
    else $error("event not following output");
  pin_enable_a: assert property (
    ##1 pin_out_en_n == !$past(ctrl_q[`ZCD_CTRL_PIN_EN]))
    else $error("pin enable wrong");
  startup_len_a: assert property (
    $rose(st_q == ZCD_ST_WAIT) |-> (st_q == ZCD_ST_WAIT)[*8])
    else $error("start-up too short");

  rise_cov_c: cover property (hit && edge_q == ZCD_EDGE_RISE);
  fall_cov_c: cover property (hit && edge_q == ZCD_EDGE_FALL);
  irq_cov_c:  cover property ($rose(irq));
  clr_cov_c:  cover property ($fell(cross_q));

endmodule
`default_nettype wire

// ---- verilog/zcd_defines.svh ----
// Purpose: Offsets, field positions, reset values and timing of the
//          zero-cross detector control block.
// Assumes: APB byte addressing, one 32-bit word per register.
// Notes:   Included by the control block and the test bench.
`ifndef ZCD_DEFINES_SVH
`define ZCD_DEFINES_SVH

// ---------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------
`define ZCD_OFF_CTRL     12'h000
`define ZCD_OFF_EDGE     12'h008
`define ZCD_OFF_STATUS   12'h00C
`define ZCD_OFF_IRQMASK  12'h010

// ---------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------
`define ZCD_CTRL_ENABLE  0
`define ZCD_CTRL_INVERT  3
`define ZCD_CTRL_PIN_EN  6
`define ZCD_CTRL_STDBY   7
`define ZCD_ST_CROSS     0
`define ZCD_ST_STATE     4
`define ZCD_ST_READY     5

// ---------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------
`define ZCD_CTRL_RST     8'h00
`define ZCD_EDGE_RST     2'h0
`define ZCD_MASK_RST     1'h1

// ---------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------
`define ZCD_CLK_MHZ      200
`define ZCD_STARTUP_NS   2000
`define ZCD_STARTUP_CYC  ((`ZCD_STARTUP_NS * `ZCD_CLK_MHZ + 999) / 1000)

`endif

// ---- verilog/zcd_pkg.sv ----
// Purpose: Types of the zero-cross detector control block.
// Assumes: zcd_defines.svh holds all numbers except the enum encodings below.
// Notes:   Edge-select encoding of the crossing interrupt.
package zcd_pkg;

  // -------------------------------------------------------------------
  // Edge select and start-up states
  // -------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    ZCD_EDGE_OFF  = 2'h0,
    ZCD_EDGE_RISE = 2'h1,
    ZCD_EDGE_FALL = 2'h2,
    ZCD_EDGE_BOTH = 2'h3
  } zcd_edge_t;

  typedef enum logic [1:0]
  {
    ZCD_ST_OFF  = 2'h0,
    ZCD_ST_WAIT = 2'h1,
    ZCD_ST_RUN  = 2'h2
  } zcd_state_t;

endpackage

// ---- verilog/zcd_sync.sv ----
// Purpose: Two-stage synchroniser for the comparator level.
// Assumes: Input is asynchronous to pclk.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module zcd_sync
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output var  logic sync_out
);

  logic meta_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
`default_nettype wire
